// ### rtl/bcpa_pkg.sv
package bcpa_pkg;
    // operating mode as strapped at reset (normal 0..2, special 3..5, peripheral 6; each group single-chip, expanded, narrow)
    typedef enum logic [2:0] {
        MODE_NORM_SC,
        MODE_NORM_EXP,
        MODE_NORM_NARROW,
        MODE_SPEC_SC,
        MODE_SPEC_EXP,
        MODE_SPEC_NARROW,
        MODE_PERIPH
    } bcpa_mode_e;

    // word offsets (byte addresses) of our registers
    localparam logic [3:0] ADDR_ASSIGN = 4'h0;
    localparam logic [3:0] ADDR_PULLUP = 4'h4;
    localparam logic [3:0] ADDR_DRIVE = 4'h8;
    localparam logic [3:0] ADDR_MODE = 4'hc;

    // field positions of port_e_assignment
    localparam int B_NODATA = 7;
    localparam int B_TESTOUT = 6;
    localparam int B_PIPE = 5;
    localparam int B_ECLK_DIS = 4;
    localparam int B_STROBE = 3;
    localparam int B_RW = 2;
    localparam int B_CAL = 1;
    localparam int B_SEL = 0;
    // e_stretch_control position in the mode register
    localparam int B_STRETCH = 0;

    // reset values of port_e_assignment per mode, then of the pull-up, drive and mode registers
    localparam logic [7:0] RST_NORM_EXP = 8'h00;
    localparam logic [7:0] RST_SPEC_EXP = 8'h2c;
    localparam logic [7:0] RST_PERIPH = 8'hd0;
    localparam logic [7:0] RST_NORM_SC = 8'h90;
    localparam logic [7:0] RST_SPEC_SC = 8'h2e;
    localparam logic [7:0] RST_PULLUP = 8'h10;
    localparam logic [7:0] RST_DRIVE = 8'h00;
    localparam logic [7:0] RST_MODE = 8'h00;
    // implemented bits of pull-up and drive registers
    localparam logic [7:0] MASK_PORTS = 8'hf3;
    // port e pins that can carry a pull-up
    localparam logic [7:0] MASK_PE_PULL = 8'h8f;
endpackage

// ### rtl/bcpa_top.sv
// Notes on behaviour
// - no_data_enable 0 gives pin e7 bus enable or inverted E; 1 gives calibration or I/O.
// - single-chip and peripheral ignore no_data_enable; e7 calibration or I/O.
// - no_data_enable: normal one write; special every write but the first.
// - clock_gen_test_enable never writable normal; special all writes but first.
// - test enable drives e6 test output except single-chip/normal expanded; pipe overrides.
// - pipe_status_enable in expanded modes makes e6/e5 queue status outputs.
// - eclock_disable: one write normal single-chip, any special single-chip, else none.
// - E clock pin is input in peripheral mode, output elsewhere.
// - e4 carries E clock when disable 0; single-chip also needs stretch 0.
// - one 16-bit write updates assignment and mode register together.
// - low_strobe_enable drives e3 strobe except single-chip or normal narrow.
// - read_write_enable drives e2 read/write; no effect in single-chip modes.
// - calibration_enable accessible in every mode but peripheral; drives e7 reference when selected.
// - pe7_output_select picks bus enable (0) or inverted E (1) in expanded.
// - inverted E clock is exact opposite of E clock, may idle high.
// - pull enables act only on pins configured as inputs.
// - port e pull acts on pins 7,3,2,1,0 only.
// - port j and h enables load every input pin of their port.
// - pull-up register absent in peripheral mode.
// - assignment reset value depends on operating mode.
`timescale 1ns/10ps
`default_nettype none
module bcpa_top
    import bcpa_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire bcpa_pkg::bcpa_mode_e i_mode,
    input wire logic [3:0] i_address,
    input wire logic i_read,
    input wire logic i_write,
    input wire logic [31:0] i_writedata,
    input wire logic [3:0] i_byteenable,
    output logic [31:0] o_readdata,
    output logic o_waitrequest,
    input wire logic i_eclk,
    input wire logic i_data_bus_enable,
    input wire logic i_low_byte_strobe,
    input wire logic i_rw,
    input wire logic i_clock_generator_test,
    input wire logic [1:0] i_pipe_status,
    input wire logic [7:0] i_pe_gpio_dir,
    input wire logic [7:0] i_pe_gpio_out,
    input wire logic [7:0] i_port_a_dir,
    input wire logic [7:0] i_port_b_dir,
    input wire logic [7:0] i_port_h_dir,
    input wire logic [7:0] i_port_j_dir,
    input wire logic [7:0] i_port_k_dir,
    output logic [7:0] o_pe_out,
    output logic [7:0] o_pe_oe,
    output logic [7:0] o_pe_pull,
    output logic [7:0] o_port_a_pull,
    output logic [7:0] o_port_b_pull,
    output logic [7:0] o_port_h_load,
    output logic [7:0] o_port_j_load,
    output logic [7:0] o_port_k_pull,
    output logic [5:0] o_low_drive
);
    import bcpa_pkg::*;

    logic [7:0] assign_q;
    logic [7:0] written_q;
    logic [7:0] pullup_q;
    logic [7:0] drive_q;
    logic drive_written_q;
    logic [7:0] mode_q;
    logic init_q;
    logic ack_q;
    logic special;
    logic single_chip;
    logic periph;
    logic expanded;
    logic norm_narrow;
    logic norm_exp;
    logic [7:0] wmask;
    logic [7:0] wdata0;
    logic [7:0] wdata1;
    logic wr_go;
    logic rd_go;
    logic [7:0] pe_alt;
    logic [7:0] pe_alt_out;
    logic [7:0] pe_alt_oe;

    // policy for a write to one policed bit: normal writes once, special skips the first
    function automatic logic may_write(input logic spec, input logic first_done,
                                       input logic never_normal);
        if (spec)
            may_write = first_done;
        else
            may_write = !never_normal && !first_done;
    endfunction

    // pull gating: enable only where the pin is an input
    function automatic logic [7:0] pull_gate(input logic en, input logic [7:0] dir);
        pull_gate = en ? ~dir : 8'h00;
    endfunction

    always_comb
    begin
        special = i_mode inside {MODE_SPEC_SC, MODE_SPEC_EXP, MODE_SPEC_NARROW};
        single_chip = i_mode inside {MODE_NORM_SC, MODE_SPEC_SC};
        periph = (i_mode == MODE_PERIPH);
        expanded = !single_chip && !periph;
        norm_narrow = (i_mode == MODE_NORM_NARROW);
        norm_exp = i_mode inside {MODE_NORM_EXP, MODE_NORM_NARROW};
    end

    // one wait state: read data is captured on the first edge, a write lands on the second
    assign wr_go = i_write && ack_q;
    assign rd_go = i_read && !ack_q;
    assign wdata0 = i_writedata[7:0];
    assign wdata1 = i_writedata[15:8];

    // per-bit write permission of the assignment register
    always_comb
    begin
        wmask = 8'h00;
        wmask[B_NODATA] = may_write(special, written_q[B_NODATA], 1'b0);
        wmask[B_TESTOUT] = may_write(special, written_q[B_TESTOUT], 1'b1);
        wmask[B_PIPE] = may_write(special, written_q[B_PIPE], 1'b0);
        wmask[B_STROBE] = may_write(special, written_q[B_STROBE], 1'b0);
        wmask[B_RW] = may_write(special, written_q[B_RW], 1'b0);
        wmask[B_SEL] = may_write(special, written_q[B_SEL], 1'b0);
        wmask[B_CAL] = 1'b1;
        if (i_mode == MODE_NORM_SC)
            wmask[B_ECLK_DIS] = !written_q[B_ECLK_DIS];
        else
            wmask[B_ECLK_DIS] = (i_mode == MODE_SPEC_SC);
        if (periph)
            wmask = 8'h00;
    end

    // bus handshake
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
            ack_q <= 1'b0;
        else
            ack_q <= (i_read || i_write) && !ack_q;
    end

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
            o_waitrequest <= 1'b1;
        else
            o_waitrequest <= !((i_read || i_write) && !ack_q);
    end

    // mode-dependent reset value is loaded one clock after release, since the
    // strap may not reach an async-reset flop
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
            init_q <= 1'b1;
        else
            init_q <= 1'b0;
    end

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            assign_q <= RST_NORM_EXP;
            written_q <= 8'h00;
        end
        else if (init_q)
        begin
            unique case (i_mode)
                MODE_NORM_SC: assign_q <= RST_NORM_SC;
                MODE_SPEC_SC: assign_q <= RST_SPEC_SC;
                MODE_SPEC_EXP, MODE_SPEC_NARROW: assign_q <= RST_SPEC_EXP;
                MODE_PERIPH: assign_q <= RST_PERIPH;
                MODE_NORM_EXP, MODE_NORM_NARROW: assign_q <= RST_NORM_EXP;
            endcase
        end
        else if (wr_go && i_address == ADDR_ASSIGN && i_byteenable[0])
        begin
            // first write is recorded per bit whether or not it lands
            assign_q <= (assign_q & ~wmask) | (wdata0 & wmask);
            written_q <= written_q | (periph ? 8'h00 : 8'hff);
        end
    end

    // mode register shares the write: byte lane 1 of the same word
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
            mode_q <= RST_MODE;
        else if (wr_go && i_address == ADDR_ASSIGN && i_byteenable[1])
            mode_q <= wdata1;
        else if (wr_go && i_address == ADDR_MODE && i_byteenable[0])
            mode_q <= wdata0;
    end

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
            pullup_q <= RST_PULLUP;
        else if (wr_go && i_address == ADDR_PULLUP && i_byteenable[0] && !periph)
            pullup_q <= wdata0 & MASK_PORTS;
    end

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            drive_q <= RST_DRIVE;
            drive_written_q <= 1'b0;
        end
        else if (wr_go && i_address == ADDR_DRIVE && i_byteenable[0] && !periph)
        begin
            if (may_write(special, drive_written_q, 1'b0))
                drive_q <= wdata0 & MASK_PORTS;
            drive_written_q <= 1'b1;
        end
    end

    // read data; unmapped or absent registers read zero
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
            o_readdata <= 32'h0000_0000;
        else if (rd_go)
        begin
            unique case (i_address)
                ADDR_ASSIGN: o_readdata <= periph ? 32'h0 : {16'h0, mode_q, assign_q};
                ADDR_PULLUP: o_readdata <= periph ? 32'h0 : {24'h0, pullup_q};
                ADDR_DRIVE: o_readdata <= periph ? 32'h0 : {24'h0, drive_q};
                ADDR_MODE: o_readdata <= {24'h0, mode_q};
                default: o_readdata <= 32'h0;
            endcase
        end
    end

    // alternate function selection per port e pin
    always_comb
    begin
        pe_alt = 8'h00;
        pe_alt_out = 8'h00;
        pe_alt_oe = 8'h00;
        if (expanded && !assign_q[B_NODATA])
        begin
            pe_alt[7] = 1'b1;
            pe_alt_oe[7] = 1'b1;
            pe_alt_out[7] = assign_q[B_SEL] ? !i_eclk : i_data_bus_enable;
        end
        else if (assign_q[B_CAL])
        begin
            pe_alt[7] = 1'b1;
            pe_alt_oe[7] = 1'b1;
            pe_alt_out[7] = i_eclk;
        end
        if (expanded && assign_q[B_PIPE])
        begin
            pe_alt[6:5] = 2'b11;
            pe_alt_oe[6:5] = 2'b11;
            pe_alt_out[6:5] = i_pipe_status;
        end
        else if (assign_q[B_TESTOUT] && !single_chip && !norm_exp)
        begin
            pe_alt[6] = 1'b1;
            pe_alt_oe[6] = 1'b1;
            pe_alt_out[6] = i_clock_generator_test;
        end
        // peripheral mode takes e4 as the E input whatever the disable bit says
        if (periph || (!assign_q[B_ECLK_DIS] && !(single_chip && mode_q[B_STRETCH])))
        begin
            pe_alt[4] = 1'b1;
            pe_alt_oe[4] = !periph;
            pe_alt_out[4] = i_eclk;
        end
        if (assign_q[B_STROBE] && !single_chip && !norm_narrow)
        begin
            pe_alt[3] = 1'b1;
            pe_alt_oe[3] = 1'b1;
            pe_alt_out[3] = i_low_byte_strobe;
        end
        if (assign_q[B_RW] && !single_chip)
        begin
            pe_alt[2] = 1'b1;
            pe_alt_oe[2] = 1'b1;
            pe_alt_out[2] = i_rw;
        end
    end

    // pins drive from flops; pins 1:0 are interrupt inputs and never drive
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_pe_out <= 8'h00;
            o_pe_oe <= 8'h00;
            o_pe_pull <= 8'h00;
        end
        else
        begin
            o_pe_out <= (pe_alt_out & pe_alt) | (i_pe_gpio_out & ~pe_alt & 8'hfc);
            o_pe_oe <= (pe_alt_oe & pe_alt) | (i_pe_gpio_dir & ~pe_alt & 8'hfc);
            o_pe_pull <= pull_gate(pullup_q[4], (pe_alt_oe & pe_alt) |
                (i_pe_gpio_dir & ~pe_alt & 8'hfc)) & MASK_PE_PULL;
        end
    end

    // other ports: enable applies only to input pins
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_port_a_pull <= 8'h00;
            o_port_b_pull <= 8'h00;
            o_port_h_load <= 8'h00;
            o_port_j_load <= 8'h00;
            o_port_k_pull <= 8'h00;
            o_low_drive <= 6'h00;
        end
        else
        begin
            o_port_a_pull <= pull_gate(pullup_q[0], i_port_a_dir);
            o_port_b_pull <= pull_gate(pullup_q[1], i_port_b_dir);
            o_port_h_load <= pull_gate(pullup_q[5], i_port_h_dir);
            o_port_j_load <= pull_gate(pullup_q[6], i_port_j_dir);
            o_port_k_pull <= pull_gate(pullup_q[7], i_port_k_dir);
            o_low_drive <= {drive_q[7:4], drive_q[1:0]};
        end
    end

    // pipe status may only show up on pins in expanded modes
    pipe_mode_a: assert property (@(posedge i_clk) disable iff (i_rst)
        !expanded |=> !(o_pe_oe[5] && !$past(i_pe_gpio_dir[5]) && $past(assign_q[B_PIPE])))
        else $error("pipe status driven outside expanded mode");
    // a normal-mode write never changes the test enable
    test_never_a: assert property (@(posedge i_clk) disable iff (i_rst || init_q)
        (!special && !periph) |=> $stable(assign_q[B_TESTOUT]) || $past(init_q))
        else $error("test enable changed in normal mode");
    // e clock pin is not driven in peripheral mode
    eclk_dir_a: assert property (@(posedge i_clk) disable iff (i_rst)
        periph && $stable(i_mode) |=> !o_pe_oe[4])
        else $error("e clock driven in peripheral mode");
    // pull never on a pin the port drives
    pull_input_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (o_pe_pull & o_pe_oe) == 8'h00)
        else $error("pull on driven pin");
    // pins 6..4 never pulled
    pull_pins_a: assert property (@(posedge i_clk) disable iff (i_rst)
        o_pe_pull[6:4] == 3'b000)
        else $error("pull on pin 6..4");
    // second normal-mode write of no_data_enable is blocked
    once_nodata_a: assert property (@(posedge i_clk) disable iff (i_rst)
        !special && !periph && written_q[B_NODATA] && !init_q |=> $stable(assign_q[B_NODATA]))
        else $error("no_data_enable rewritten in normal mode");
    // special-mode first write of read_write_enable never lands
    first_skip_a: assert property (@(posedge i_clk) disable iff (i_rst)
        special && !init_q && !written_q[B_RW] |=> $stable(assign_q[B_RW]))
        else $error("first special write landed");
    // accesses are answered on the second edge
    bus_answer_a: assert property (@(posedge i_clk) disable iff (i_rst)
        $rose(i_read || i_write) && o_waitrequest |=> !o_waitrequest)
        else $error("bus answer late");
endmodule
`default_nettype wire

// ### tb/bcpa_far_model.sv
`timescale 1ns/10ps
`default_nettype none
// far side of port e: resolves each wire from the design's drive and pulls
module bcpa_far_model
(
    input wire logic [7:0] i_pe_out,
    input wire logic [7:0] i_pe_oe,
    input wire logic [7:0] i_pe_pull,
    input wire logic i_tag_on,
    input wire logic i_clk,
    output logic [7:0] o_pe_level
);
    logic [7:0] float_q = 8'ha5;
    logic tag_q = 1'b0;
    // a floating wire keeps changing so a stale level never passes for a drive
    always @(posedge i_clk)
    begin
        float_q <= ~float_q;
    end
    // tag the low byte: e3 pulled low from the falling edge of E until E rises again
    always @(i_pe_out[4])
    begin
        tag_q <= i_tag_on && !i_pe_out[4];
    end
    // driver wins, then pull-up, else floating
    always_comb
    begin
        for (int i = 0; i < 8; i++)
        begin
            o_pe_level[i] = i_pe_oe[i] ? i_pe_out[i] : (i_pe_pull[i] ? 1'b1 : float_q[i]);
        end
        if (tag_q)
            o_pe_level[3] = 1'b0;
    end
endmodule
`default_nettype wire

// ### tb/bus_control_pin_assign_bench.sv
`timescale 1ns/10ps
`default_nettype none
module bus_control_pin_assign_bench;
    import bcpa_pkg::*;
    logic i_clk, i_rst, i_read, i_write, i_eclk, i_data_bus_enable, i_low_byte_strobe, i_rw;
    logic i_clock_generator_test, o_waitrequest;
    bcpa_mode_e i_mode;
    logic [3:0] i_address, i_byteenable;
    logic [31:0] i_writedata, o_readdata, rq;
    logic [1:0] i_pipe_status;
    logic [7:0] i_pe_gpio_dir, i_pe_gpio_out, i_port_a_dir, i_port_b_dir, i_port_h_dir;
    logic [7:0] i_port_j_dir, i_port_k_dir, o_pe_out, o_pe_oe, o_pe_pull, o_port_a_pull;
    logic [7:0] o_port_b_pull, o_port_h_load, o_port_j_load, o_port_k_pull, pe_level;
    logic [5:0] o_low_drive;
    logic [7:0] rv [7] = '{8'h90, 8'h00, 8'h00, 8'h2e, 8'h2c, 8'h2c, 8'hd0};
    int fails = 0;
    int compares = 0;

    bcpa_top dut_u (.i_clk, .i_rst, .i_mode, .i_address, .i_read, .i_write, .i_writedata,
        .i_byteenable, .o_readdata, .o_waitrequest, .i_eclk, .i_data_bus_enable,
        .i_low_byte_strobe, .i_rw, .i_clock_generator_test, .i_pipe_status, .i_pe_gpio_dir,
        .i_pe_gpio_out, .i_port_a_dir, .i_port_b_dir, .i_port_h_dir, .i_port_j_dir,
        .i_port_k_dir, .o_pe_out, .o_pe_oe, .o_pe_pull, .o_port_a_pull, .o_port_b_pull,
        .o_port_h_load, .o_port_j_load, .o_port_k_pull, .o_low_drive);
    bcpa_far_model far_u (.i_pe_out(o_pe_out), .i_pe_oe(o_pe_oe), .i_pe_pull(o_pe_pull),
        .i_tag_on(1'b0), .i_clk(i_clk), .o_pe_level(pe_level));

    // free-running 100 MHz clock
    always #5 i_clk = ~i_clk;

    task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
        compares++;
        if (got !== exp)
        begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic complete_run();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // one avalon transfer: hold everything until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [3:0] a, input logic [3:0] be,
        input logic [31:0] d);
        int n;
        n = 0;
        i_address <= a;
        i_byteenable <= be;
        i_writedata <= d;
        i_read <= !wr;
        i_write <= wr;
        do
        begin
            @(posedge i_clk);
            n++;
        end
        while (o_waitrequest !== 1'b0 && n < 40);
        rq = o_readdata;
        if (n >= 40)
            chk("handshake", 0, 1);
        i_read <= 1'b0;
        i_write <= 1'b0;
        @(posedge i_clk);
    endtask

    // byte write then read back through lane 0
    task automatic wrc(input logic [3:0] a, input logic [7:0] d, input logic [7:0] exp);
        bus(1'b1, a, 4'h1, {24'h0, d});
        bus(1'b0, a, 4'h1, 32'h0);
        chk("register", exp, rq[7:0]);
    endtask

    // mode is strapped during reset; first request two edges after release
    task automatic rst_mode(input bcpa_mode_e m);
        i_mode <= m;
        i_rst <= 1'b1;
        repeat (2) @(posedge i_clk);
        i_rst <= 1'b0;
        repeat (2) @(posedge i_clk);
    endtask

    // expected pin map from assignment value, stretch bit and pull register
    task automatic pins(input bcpa_mode_e m, input logic [7:0] a, input logic e_stretch_control,
        input logic [7:0] pu);
        logic sc, per, ex;
        logic [6:0] s;
        logic [7:0] eoe, eout, d;
        sc = (m == MODE_NORM_SC) || (m == MODE_SPEC_SC);
        per = (m == MODE_PERIPH);
        ex = !sc && !per;
        for (int k = 0; k < 2; k++)
        begin
            s = k ? 7'h56 : 7'h29;
            d = k ? 8'hcc : 8'h30;
            {i_eclk, i_data_bus_enable, i_low_byte_strobe, i_rw, i_clock_generator_test,
                i_pipe_status} <= s;
            i_pe_gpio_dir <= d;
            i_pe_gpio_out <= ~d;
            {i_port_a_dir, i_port_b_dir, i_port_h_dir, i_port_j_dir, i_port_k_dir} <= {5{d}};
            repeat (3) @(posedge i_clk);
            eoe = {d[7:2], 2'b00};
            eout = ~d;
            if (ex && !a[7])
                {eoe[7], eout[7]} = {1'b1, a[0] ? !s[6] : s[5]};
            else if (a[1])
                {eoe[7], eout[7]} = {1'b1, s[6]};
            if (ex && a[5])
                {eoe[6:5], eout[6:5]} = {2'b11, s[1:0]};
            else if (a[6] && (per || m == MODE_SPEC_EXP || m == MODE_SPEC_NARROW))
                {eoe[6], eout[6]} = {1'b1, s[2]};
            if (per)
                eoe[4] = 1'b0;
            else if (!a[4] && !(sc && e_stretch_control))
                {eoe[4], eout[4]} = {1'b1, s[6]};
            if (a[3] && !sc && m != MODE_NORM_NARROW)
                {eoe[3], eout[3]} = {1'b1, s[4]};
            if (a[2] && !sc)
                {eoe[2], eout[2]} = {1'b1, s[3]};
            chk("pin enable", eoe, o_pe_oe);
            chk("pin value", eout & eoe, o_pe_out & eoe);
            if (eoe[4])
                chk("e4 wire", s[6], pe_level[4]);
            if (!per)
            begin
                chk("pe pull", {8{pu[4]}} & ~eoe & 8'h8f, o_pe_pull);
                chk("port pulls", {{8{pu[0]}}, {8{pu[1]}}, {8{pu[5]}}, {8{pu[6]}},
                    {8{pu[7]}}} & {5{~d}}, {o_port_a_pull, o_port_b_pull, o_port_h_load,
                    o_port_j_load, o_port_k_pull});
            end
        end
    endtask

    // watchdog: the whole sequence needs a few hundred cycles at most
    initial
    begin
        repeat (20000) @(posedge i_clk);
        fails++;
        complete_run();
    end

    // main sequence
    initial
    begin
        i_clk = 1'b0;
        i_rst = 1'b1;
        i_mode = MODE_NORM_EXP;
        {i_read, i_write, i_address, i_byteenable, i_writedata} = '0;
        {i_eclk, i_data_bus_enable, i_low_byte_strobe, i_rw, i_clock_generator_test} = '0;
        {i_pipe_status, i_pe_gpio_dir, i_pe_gpio_out} = '0;
        {i_port_a_dir, i_port_b_dir, i_port_h_dir, i_port_j_dir, i_port_k_dir} = '0;
        repeat (2) @(posedge i_clk);
        i_rst <= 1'b0;
        @(posedge i_clk);
        for (int i = 0; i < 7; i++)
        begin
            rst_mode(bcpa_mode_e'(i));
            bus(1'b0, 4'h0, 4'h1, 32'h0);
            chk("assign reset", i == 6 ? 0 : rv[i], rq[7:0]);
            bus(1'b0, 4'h4, 4'h1, 32'h0);
            chk("pullup reset", i == 6 ? 0 : 8'h10, rq[7:0]);
            bus(1'b0, 4'h8, 4'h1, 32'h0);
            chk("drive reset", 0, rq[7:0]);
            pins(bcpa_mode_e'(i), rv[i], 1'b0, 8'h10);
        end
        rst_mode(MODE_NORM_EXP);
        wrc(4'h0, 8'hff, 8'haf);
        pins(MODE_NORM_EXP, 8'haf, 1'b0, 8'h10);
        wrc(4'h0, 8'h00, 8'had);
        wrc(4'h4, 8'hff, 8'hf3);
        pins(MODE_NORM_EXP, 8'had, 1'b0, 8'hf3);
        wrc(4'h4, 8'h10, 8'h10);
        wrc(4'h8, 8'hff, 8'hf3);
        chk("low drive", 6'h3f, o_low_drive);
        wrc(4'h8, 8'h00, 8'hf3);
        bus(1'b0, 4'h2, 4'hf, 32'h0);
        chk("unmapped", 0, rq);
        rst_mode(MODE_NORM_EXP);
        wrc(4'h0, 8'h01, 8'h01);
        pins(MODE_NORM_EXP, 8'h01, 1'b0, 8'h10);
        rst_mode(MODE_NORM_NARROW);
        wrc(4'h0, 8'h0c, 8'h0c);
        pins(MODE_NORM_NARROW, 8'h0c, 1'b0, 8'h10);
        rst_mode(MODE_SPEC_EXP);
        wrc(4'h0, 8'hff, 8'h2e);
        wrc(4'h0, 8'h40, 8'h40);
        pins(MODE_SPEC_EXP, 8'h40, 1'b0, 8'h10);
        wrc(4'h0, 8'h60, 8'h60);
        pins(MODE_SPEC_EXP, 8'h60, 1'b0, 8'h10);
        wrc(4'h0, 8'h82, 8'h82);
        pins(MODE_SPEC_EXP, 8'h82, 1'b0, 8'h10);
        wrc(4'h8, 8'hff, 8'h00);
        wrc(4'h8, 8'hff, 8'hf3);
        rst_mode(MODE_NORM_SC);
        bus(1'b1, 4'h0, 4'h3, 32'h0100);
        bus(1'b0, 4'h0, 4'h3, 32'h0);
        chk("assign and mode", 16'h0100, rq[15:0]);
        pins(MODE_NORM_SC, 8'h00, 1'b1, 8'h10);
        wrc(4'hc, 8'h00, 8'h00);
        pins(MODE_NORM_SC, 8'h00, 1'b0, 8'h10);
        wrc(4'h0, 8'hff, 8'h02);
        rst_mode(MODE_SPEC_SC);
        wrc(4'h0, 8'h10, 8'h3c);
        pins(MODE_SPEC_SC, 8'h3c, 1'b0, 8'h10);
        wrc(4'h0, 8'h00, 8'h00);
        rst_mode(MODE_PERIPH);
        wrc(4'h0, 8'hff, 8'h00);
        wrc(4'h4, 8'hff, 8'h00);
        complete_run();
    end
endmodule
`default_nettype wire
